// ---- verilog/sdc_ctrl.v ----
// SDRAM control register file and the command, clock enable and timing logic it steers
`include "sdc_regs.vh"

module sdc_ctrl (
	input wire I_CORE_CLK,
	input wire I_RESET,
	input wire [31:0] I_ADDR,
	input wire [31:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	output reg [31:0] O_RDATA,
	input wire I_ACCESS_REQ,
	input wire I_REFRESH_TICK,
	input wire I_LINK_CLK,
	output wire O_BUS16,
	output wire [3:0] O_COL_BITS,
	output wire [3:0] O_ROW_BITS,
	output wire O_FOUR_BANKS,
	output reg [2:0] O_CMD,
	output reg [7:0] O_MODE_DATA,
	output reg O_CKE,
	output wire O_CLK_RUN,
	output wire O_ACT_ALLOWED,
	output reg O_LINK_EDGE
);
	localparam ST_OFF = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_PDN = 2'h2;
	localparam ST_SREF = 2'h3;

	reg [31:0] ctrl_reg;
	reg [31:0] ctrl_next;
	reg [15:0] rtcs_reg;
	reg [15:0] rtcn_reg;
	reg [15:0] rtco_reg;
	reg [31:0] bank_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [2:0] cmd_next;
	reg cke_next;
	reg cke_bit_d_reg;
	reg lclk_s1_reg;
	reg lclk_s2_reg;
	reg lclk_s3_reg;
	wire wr_ctrl;
	wire wr_mode;
	wire cke_rise;
	wire pre_issued;
	wire sref_issued;
	wire srh_busy;
	wire pcw_busy;
	wire [3:0] srh_count;
	wire [3:0] pcw_count;
	wire idle;

	assign wr_ctrl = I_WR && (I_ADDR == `SDC_OFF_CTRL);
	assign wr_mode = I_WR && (I_ADDR == `SDC_OFF_MODE);

	// Register writes; masked bits never store so reserved ones read zero
	always @* begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next = I_WDATA & `SDC_CTRL_WMASK;
		end
	end

	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			ctrl_reg <= `SDC_RST_CTRL;
			rtcs_reg <= `SDC_RST_R16;
			rtcn_reg <= `SDC_RST_R16;
			rtco_reg <= `SDC_RST_R16;
			bank_reg <= `SDC_RST_BANK;
			cke_bit_d_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			cke_bit_d_reg <= ctrl_reg[`SDC_BIT_CKE];
			if (I_WR && (I_ADDR == `SDC_OFF_RTCS)) begin
				rtcs_reg <= I_WDATA[15:0];
			end
			if (I_WR && (I_ADDR == `SDC_OFF_RTCN)) begin
				rtcn_reg <= I_WDATA[15:0];
			end
			if (I_WR && (I_ADDR == `SDC_OFF_RTCO)) begin
				rtco_reg <= I_WDATA[15:0];
			end
			if (I_WR && (I_ADDR == `SDC_OFF_BANK)) begin
				bank_reg <= I_WDATA;
			end
		end
	end

	// Read data stands only in the cycle after the strobe; the mode window is write-only and reads zero
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_RDATA <= 32'h00000000;
		end else if (I_RD) begin
			case (I_ADDR)
				`SDC_OFF_CTRL: O_RDATA <= ctrl_reg;
				`SDC_OFF_RTCS: O_RDATA <= {16'h0000, rtcs_reg};
				`SDC_OFF_RTCN: O_RDATA <= {16'h0000, rtcn_reg};
				`SDC_OFF_RTCO: O_RDATA <= {16'h0000, rtco_reg};
				`SDC_OFF_BANK: O_RDATA <= bank_reg;
				default: O_RDATA <= 32'h00000000;
			endcase
		end else begin
			O_RDATA <= 32'h00000000;
		end
	end

	// Geometry decode; reserved codes give whatever the adder yields
	assign O_BUS16 = ctrl_reg[`SDC_BIT_BW];
	assign O_COL_BITS = `SDC_CA_BASE + {1'b0, ctrl_reg[`SDC_CA_HI:`SDC_CA_LO]};
	assign O_ROW_BITS = `SDC_RA_BASE + {2'b00, ctrl_reg[`SDC_RA_HI:`SDC_RA_LO]};
	assign O_FOUR_BANKS = ctrl_reg[`SDC_BIT_BANK];

	// Rising edge of the clock enable control bit asks for power-down exit
	assign cke_rise = ctrl_reg[`SDC_BIT_CKE] && !cke_bit_d_reg;
	assign idle = !I_ACCESS_REQ && !(I_REFRESH_TICK && ctrl_reg[`SDC_BIT_RFEN]);

	assign srh_count = `SDC_SRH_BASE + {1'b0, ctrl_reg[`SDC_SRH_HI:`SDC_SRH_LO]};
	assign pcw_count = `SDC_PCW_BASE + {1'b0, ctrl_reg[`SDC_PCW_HI:`SDC_PCW_LO]};
	assign sref_issued = (cmd_next == `SDC_CMD_SREF);
	assign pre_issued = (cmd_next == `SDC_CMD_PRECHARGE_ALL_BANKS_CMD);

	// Command sequencer: one command per cycle, from flip-flops
	always @* begin
		state_next = state_reg;
		cmd_next = `SDC_CMD_NOP;
		cke_next = O_CKE;
		case (state_reg)
			ST_OFF: begin
				cke_next = 1'b0;
				if (cke_rise) begin
					cmd_next = `SDC_CMD_PDX;
					cke_next = 1'b1;
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!ctrl_reg[`SDC_BIT_CKE]) begin
					cke_next = 1'b0;
					state_next = ST_OFF;
				end else if (wr_mode) begin
					cmd_next = ctrl_reg[`SDC_BIT_MSET] ? `SDC_CMD_MRS : `SDC_CMD_PRECHARGE_ALL_BANKS_CMD;
				end else if (I_REFRESH_TICK && ctrl_reg[`SDC_BIT_RFEN]) begin
					if (ctrl_reg[`SDC_BIT_RKIND]) begin
						cmd_next = `SDC_CMD_SREF;
						cke_next = 1'b0;
						state_next = ST_SREF;
					end else begin
						cmd_next = `SDC_CMD_AREF;
					end
				end else if (I_ACCESS_REQ && !pcw_busy) begin
					cmd_next = `SDC_CMD_ACT;
				end else if (ctrl_reg[`SDC_BIT_PDM] && idle) begin
					cke_next = 1'b0;
					state_next = ST_PDN;
				end
			end
			ST_PDN: begin
				// Only exit may follow power-down
				if (!ctrl_reg[`SDC_BIT_CKE]) begin
					state_next = ST_OFF;
				end else if (!idle || !ctrl_reg[`SDC_BIT_PDM] || wr_mode) begin
					cmd_next = `SDC_CMD_PDX;
					cke_next = 1'b1;
					state_next = ST_RUN;
				end
			end
			ST_SREF: begin
				// Leave self-refresh once the hold is over and either refresh stops being wanted or an access is requested
				if (!srh_busy && !sref_issued && (!ctrl_reg[`SDC_BIT_RFEN] || !ctrl_reg[`SDC_BIT_RKIND] ||
					I_ACCESS_REQ)) begin
					if (ctrl_reg[`SDC_BIT_CKE]) begin
						cmd_next = `SDC_CMD_PDX;
						cke_next = 1'b1;
						state_next = ST_RUN;
					end else begin
						state_next = ST_OFF;
					end
				end
			end
			default: begin
				state_next = ST_OFF;
				cke_next = 1'b0;
			end
		endcase
	end

	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			state_reg <= ST_OFF;
			O_CMD <= `SDC_CMD_NOP;
			O_CKE <= 1'b0;
			O_MODE_DATA <= 8'h00;
		end else begin
			state_reg <= state_next;
			O_CMD <= cmd_next;
			O_CKE <= cke_next;
			if (wr_mode) begin
				O_MODE_DATA <= I_WDATA[7:0];
			end
		end
	end

	// The hold counter loads one less because the cycle after loading already counts
	sdc_wait_cnt #(
		.W(4)
	) u_srh (
		.i_clk(I_CORE_CLK),
		.i_reset(I_RESET),
		.i_load(sref_issued),
		.i_count(srh_count - 4'h1),
		.o_busy(srh_busy)
	);

	sdc_wait_cnt #(
		.W(4)
	) u_pcw (
		.i_clk(I_CORE_CLK),
		.i_reset(I_RESET),
		.i_load(pre_issued),
		.i_count(pcw_count),
		.o_busy(pcw_busy)
	);

	assign O_ACT_ALLOWED = !pcw_busy && (state_reg == ST_RUN);
	assign O_CLK_RUN = (state_reg == ST_RUN);

	// Link clock is sampled and edge-detected after two synchroniser stages
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			lclk_s1_reg <= 1'b0;
			lclk_s2_reg <= 1'b0;
			lclk_s3_reg <= 1'b0;
			O_LINK_EDGE <= 1'b0;
		end else begin
			lclk_s1_reg <= I_LINK_CLK;
			lclk_s2_reg <= lclk_s1_reg;
			lclk_s3_reg <= lclk_s2_reg;
			O_LINK_EDGE <= lclk_s2_reg && !lclk_s3_reg;
		end
	end
endmodule

// ---- verilog/sdc_regs.vh ----
// Register offsets, field positions, reset values and timing codes of the SDRAM control block
`ifndef SDC_REGS_VH
`define SDC_REGS_VH
`define SDC_ADDR_W 32
`define SDC_OFF_CTRL 32'h13010080
`define SDC_OFF_RTCS 32'h13010084
`define SDC_OFF_RTCN 32'h13010088
`define SDC_OFF_RTCO 32'h1301008c
`define SDC_OFF_BANK 32'h13010090
`define SDC_OFF_MODE 32'h1301a000
`define SDC_RST_CTRL 32'h00000000
`define SDC_RST_R16 16'h0000
`define SDC_RST_BANK 32'h000020f8
`define SDC_CTRL_WMASK 32'h9fbeff7f
`define SDC_MODE_WMASK 32'h000000ff
`define SDC_BIT_BW 31
`define SDC_CA_HI 28
`define SDC_CA_LO 26
`define SDC_BIT_RKIND 25
`define SDC_BIT_RFEN 24
`define SDC_BIT_MSET 23
`define SDC_RA_HI 21
`define SDC_RA_LO 20
`define SDC_BIT_BANK 19
`define SDC_BIT_PDM 18
`define SDC_BIT_CKE 17
`define SDC_SRH_HI 15
`define SDC_SRH_LO 13
`define SDC_PCW_HI 10
`define SDC_PCW_LO 8
`define SDC_SRH_BASE 4'h4
`define SDC_PCW_BASE 4'h1
`define SDC_CA_BASE 4'h8
`define SDC_RA_BASE 4'hb
`define SDC_CMD_NOP 3'h0
`define SDC_CMD_PRECHARGE_ALL_BANKS_CMD 3'h1
`define SDC_CMD_MRS 3'h2
`define SDC_CMD_AREF 3'h3
`define SDC_CMD_SREF 3'h4
`define SDC_CMD_PDX 3'h5
`define SDC_CMD_ACT 3'h6
`endif

// ---- verilog/sdc_wait_cnt.v ----
// Down counter that reports done after a loaded number of cycles
module sdc_wait_cnt #(
	parameter W = 4
) (
	input wire i_clk,
	input wire i_reset,
	input wire i_load,
	input wire [W-1:0] i_count,
	output wire o_busy
);
	reg [W-1:0] cnt_reg;
	wire [W-1:0] cnt_next;

	assign cnt_next = i_load ? i_count : ((cnt_reg != {W{1'b0}}) ? cnt_reg - {{(W-1){1'b0}}, 1'b1} : cnt_reg);
	assign o_busy = (cnt_reg != {W{1'b0}});

	always @(posedge i_clk) begin
		if (i_reset) begin
			cnt_reg <= {W{1'b0}};
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ---- verif/sdc_ctrl_sva.sv ----
// Port checker for the SDRAM control block
`include "sdc_regs.vh"
module sdc_ctrl_chk (
	input wire I_CORE_CLK,
	input wire I_RESET,
	input wire [31:0] I_ADDR,
	input wire [31:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	input wire I_ACCESS_REQ,
	input wire I_REFRESH_TICK,
	input wire [31:0] O_RDATA,
	input wire O_BUS16,
	input wire [3:0] O_COL_BITS,
	input wire [3:0] O_ROW_BITS,
	input wire O_FOUR_BANKS,
	input wire [2:0] O_CMD,
	input wire O_CKE,
	input wire O_CLK_RUN,
	input wire O_ACT_ALLOWED
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RESET);
	// Shadow of the last control write, enough for the bits the properties need
	reg [31:0] ctl;
	wire wc = I_WR && I_ADDR == `SDC_OFF_CTRL;
	wire wm = I_WR && I_ADDR == `SDC_OFF_MODE;
	always @(posedge I_CORE_CLK) ctl <= I_RESET ? 32'h0 : (wc ? I_WDATA : ctl);
	property p_geo; wc |=> O_BUS16 == ctl[31] && O_FOUR_BANKS == ctl[19]; endproperty
	a_geo: assert property (p_geo) else $error("bus width or bank select wrong");
	property p_width; wc |=> O_COL_BITS == 4'h8 + ctl[28:26] && O_ROW_BITS == 4'hb + ctl[21:20]; endproperty
	a_width: assert property (p_width) else $error("column or row width wrong");
	property p_mode; wm && O_CLK_RUN && !I_ACCESS_REQ && !I_REFRESH_TICK |=> O_CMD == (ctl[23] ? 3'h2 : 3'h1); endproperty
	a_mode: assert property (p_mode) else $error("mode window command wrong");
	property p_resv; I_RD |=> O_RDATA[30:29] == 2'h0 && O_RDATA[22] == 1'b0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
	property p_rst; $fell(I_RESET) |-> !O_CKE && O_CMD == 3'h0 && !O_BUS16 && O_ROW_BITS == 4'hb; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_pdx; $rose(ctl[17]) |=> O_CMD == `SDC_CMD_PDX && O_CKE; endproperty
	a_pdx: assert property (p_pdx) else $error("no exit command after enable");
	property p_ckeoff; !ctl[17] && !$past(ctl[17]) |-> !O_CKE; endproperty
	a_ckeoff: assert property (p_ckeoff) else $error("clock enable high while disabled");
	property p_pcw; O_CMD == `SDC_CMD_PRECHARGE_ALL_BANKS_CMD && ctl[10:8] == 3'h7 |=> !O_ACT_ALLOWED [*7]; endproperty
	a_pcw: assert property (p_pcw) else $error("activate allowed too early");
	property p_srh; O_CMD == `SDC_CMD_SREF && ctl[15:13] == 3'h7 |-> !O_CKE [*8] ##1 !O_CKE [*3]; endproperty
	a_srh: assert property (p_srh) else $error("clock enable raised too soon after self-refresh");
	c_mrs: cover property (O_CMD == `SDC_CMD_MRS);
	c_aref: cover property (O_CMD == `SDC_CMD_AREF);
	c_pdn: cover property (!O_CKE && ctl[18] && ctl[17]);
endmodule
bind sdc_ctrl sdc_ctrl_chk chk (.I_CORE_CLK, .I_RESET, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_ACCESS_REQ,
	.I_REFRESH_TICK, .O_RDATA, .O_BUS16, .O_COL_BITS, .O_ROW_BITS, .O_FOUR_BANKS, .O_CMD, .O_CKE, .O_CLK_RUN,
	.O_ACT_ALLOWED);

// ---- verif/sdc_sdram_model.sv ----
// Behavioural SDRAM chip that flags commands it must never see
module sdc_sdram_model (
	input wire clk,
	input wire [2:0] cmd,
	input wire cke,
	output reg err = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	reg cke_q = 1'b0;
	reg woke = 1'b0;
	always @(posedge clk) begin
		cke_q <= cke;
		if (cmd == 3'h5)
			woke <= 1'b1;
		// Asleep: only NOP or the wake-up code may arrive
		if (!cke_q && cmd != 3'h0 && cmd != 3'h5)
			err <= 1'b1;
		// A row opened before wake-up means init was skipped
		if (!woke && cmd == 3'h6)
			err <= 1'b1;
	end
endmodule

// ---- verif/sdc_ctrl_test.sv ----
// Self-checking bench for the SDRAM control block
`include "sdc_regs.vh"
module sdc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, wr = 0, rd = 0, acc = 0, tick = 0, lclk = 0;
	logic [31:0] addr = 0, wd = 0, rdat;
	logic [2:0] cmd;
	logic [3:0] colb, rowb;
	logic [7:0] mdat;
	logic b16, fb, cke, crun, actok, ledge, err;
	int bad_count = 0, num_checks = 0, k, n;
	always #2.5 clk = ~clk;
	always #40 lclk = ~lclk;
	sdc_ctrl dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdat), .I_ACCESS_REQ(acc), .I_REFRESH_TICK(tick), .I_LINK_CLK(lclk), .O_BUS16(b16),
		.O_COL_BITS(colb), .O_ROW_BITS(rowb), .O_FOUR_BANKS(fb), .O_CMD(cmd), .O_MODE_DATA(mdat),
		.O_CKE(cke), .O_CLK_RUN(crun), .O_ACT_ALLOWED(actok), .O_LINK_EDGE(ledge));
	sdc_sdram_model mem (.clk(clk), .cmd(cmd), .cke(cke), .err(err));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
		#1;
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 cmp(rdat, e);
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic refresh(input logic [2:0] e);
		logic [2:0] seen;
		seen = 3'h0;
		@(posedge clk);
		tick <= 1;
		@(posedge clk);
		tick <= 0;
		repeat (6) begin
			#1 if (cmd !== 3'h0) seen = cmd;
			@(posedge clk);
		end
		cmp(seen, e);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		rdc(`SDC_OFF_CTRL, 32'h0);
		rdc(`SDC_OFF_BANK, `SDC_RST_BANK);
		rdc(32'h13010094, 32'h0);
		rdc(`SDC_OFF_MODE, 32'h0);
		// Only legal width codes are programmed
		for (k = 0; k < 5; k++) begin
			n = (k << 26) | ((k % 3) << 20) | ((k & 1) << 31) | ((k & 2) << 18);
			wrr(`SDC_OFF_CTRL, n | 32'h60410080);
			cmp({b16, fb}, {k[0], k[1]});
			cmp({colb, rowb}, {4'h8 + k[3:0], 4'hb + 4'(k % 3)});
			rdc(`SDC_OFF_CTRL, n);
		end
		wrr(`SDC_OFF_CTRL, 32'h00020700);
		cyc(1);
		cmp({cmd, cke, crun}, {3'h5, 2'h3});
		wrr(`SDC_OFF_MODE, 32'h5a);
		cmp(cmd, `SDC_CMD_PRECHARGE_ALL_BANKS_CMD);
		cyc(6);
		cmp(actok, 1'b0);
		cyc(6);
		cmp(actok, 1'b1);
		wrr(`SDC_OFF_CTRL, 32'h00820000);
		wrr(`SDC_OFF_MODE, 32'h33);
		cmp({cmd, mdat}, {3'h2, 8'h33});
		wrr(`SDC_OFF_CTRL, 32'h00060000);
		cyc(12);
		cmp({cke, crun}, 2'h0);
		@(posedge clk);
		acc <= 1;
		cyc(12);
		cmp(cke, 1'b1);
		@(posedge clk);
		acc <= 0;
		wrr(`SDC_OFF_CTRL, 32'h00020000);
		refresh(3'h0);
		wrr(`SDC_OFF_CTRL, 32'h01020000);
		refresh(`SDC_CMD_AREF);
		n = 0;
		repeat (400) begin
			@(posedge clk);
			#1 n += ledge;
		end
		cmp(n >= 24 && n <= 26, 1'b1);
		// Longest hold code, so an access request arrives while the hold is still running
		wrr(`SDC_OFF_CTRL, 32'h0302e000);
		refresh(`SDC_CMD_SREF);
		acc <= 1;
		cyc(1);
		cmp(cke, 1'b0);
		cyc(6);
		cmp(cke, 1'b1);
		@(posedge clk);
		acc <= 0;
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		rdc(`SDC_OFF_CTRL, 32'h0);
		cmp(err, 1'b0);
		tally_and_finish;
	end
endmodule
